//--- hw/lmd_pkg.sv
// Constants and types for the line maintenance and diagnostics control block
package lmd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_THRESH_GAIN = 8'h0c; // Threshold and monitor gain
	localparam logic [7:0] IDX_PATT_ALARM  = 8'h0d; // Pattern and alarm control
	localparam logic [7:0] IDX_LOOPBACK    = 8'h0e; // Loopback control
	localparam logic [7:0] IDX_CODE_LEN    = 8'h0f; // Inband code lengths
	localparam logic [7:0] IDX_TX_CODE     = 8'h10; // Transmit inband code
	localparam logic [7:0] IDX_RX_ACT      = 8'h11; // Receive activate code
	localparam logic [7:0] IDX_RX_DEACT    = 8'h12; // Receive deactivate code

	// Field positions
	localparam int MG_LSB     = 0; // Monitor gain select
	localparam int SLICE_LSB  = 4; // Mark threshold select
	localparam int AUTO_ALL_ONES_ENABLE_BIT   = 0; // Auto all ones
	localparam int AIS_DURING_LOS_ENABLE_BIT   = 1; // AIS during LOS
	localparam int LAC_BIT    = 2; // Alarm criterion
	localparam int PINV_BIT   = 3; // Random pattern invert
	localparam int PCLK_BIT   = 4; // Pattern clock select
	localparam int PATT_LSB   = 5; // Transmit pattern select
	localparam int DLP_BIT    = 0; // Digital loop
	localparam int ALP_BIT    = 1; // Analog loop
	localparam int RLP_BIT    = 2; // Remote loop
	localparam int AUTO_REMOTE_LOOP_ENABLE_BIT   = 3; // Auto remote loop
	localparam int RDL_LSB    = 0; // Rx deactivate length
	localparam int RAL_LSB    = 2; // Rx activate length
	localparam int TXL_LSB    = 4; // Tx code length

	// Reset values of whole registers, reserved bits included
	localparam logic [7:0] RST_THRESH_GAIN = 8'h18;
	localparam logic [7:0] RST_PATT_ALARM  = 8'h00;
	localparam logic [7:0] RST_LOOPBACK    = 8'h00;
	localparam logic [7:0] RST_CODE_LEN    = 8'h01;
	localparam logic [7:0] RST_TX_CODE     = 8'h01;
	localparam logic [7:0] RST_RX_ACT      = 8'h01;
	localparam logic [7:0] RST_RX_DEACT    = 8'h09;

	// Writable bit masks; other bits are reserved and hold reset value
	localparam logic [7:0] WM_THRESH_GAIN = 8'h33;
	localparam logic [7:0] WM_PATT_ALARM  = 8'h7f;
	localparam logic [7:0] WM_LOOPBACK    = 8'h0f;
	localparam logic [7:0] WM_CODE_LEN    = 8'h3f;

	// Pattern generators
	localparam logic [19:0] LFSR_SEED  = 20'hf_ffff; // Any nonzero seed
	localparam int          E1_TAP_A   = 14;         // x^15 + x^14 + 1
	localparam int          E1_TAP_B   = 13;
	localparam int          T1_TAP_A   = 19;         // x^20 + x^17 + 1
	localparam int          T1_TAP_B   = 16;
	localparam logic [2:0]  CODE_BASE  = 3'h4;       // Length code 0 gives 5 bits

	// Transmit pattern select encodings
	typedef enum logic [1:0] {
		PAT_NORMAL,  // Normal data or all zeros
		PAT_ONES,    // All ones
		PAT_RANDOM,  // PRBS or QRSS
		PAT_INBAND   // Repeating inband code
	} lmd_pattern_e;

	// Loopback enables as one carrier
	typedef struct packed {
		logic autoRemote; // Automatic remote loopback
		logic remote;     // Remote loopback
		logic analog;     // Analog loopback
		logic digital;    // Digital loopback
	} lmd_loop_s;

	// Inband code settings for the receive matcher
	typedef struct packed {
		logic [1:0] actLength;   // Activate code length select
		logic [7:0] actCode;     // Activate code
		logic [1:0] deactLength; // Deactivate code length select
		logic [7:0] deactCode;   // Deactivate code
	} lmd_rxcode_s;
endpackage

//--- hw/lmd_maint_ctrl.sv
// Line maintenance and diagnostics control with APB registers and pattern inserter
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Select 00: pass data, or zeros if mclk
// [R2] Select 01: transmit continuous all ones
// [R3] Select 10: PRBS15 for E1, QRSS20 otherwise
// [R4] Select 11: repeat inband code, default 00001
// [R5] Pattern timed by transmit_clock or mclk tick
// [R6] Invert bit flips random data both directions
// [R7] Criterion bit picks LOS/AIS rule set
// [R8] AIS on receive outputs during LOS if enabled
// [R9] Auto all ones during LOS when select 00
// [R10] Loop bit 3 enables automatic remote loop
// [R11] Loop bit 2 enables remote loop
// [R12] Loop bit 1 enables analog loop
// [R13] Loop bit 0 enables digital loop
// [R14] Tx code length: 5 to 8 bits
// [R15] Rx activate length: 5 to 8, default 5
// [R16] Rx deactivate length: default 6 bits
// [R17] Mark threshold 40-70 percent, reset 01
// [R18] Monitor gain 0/22/26/32 dB, reset 00
// [R19] Tx code 8 bits, low bits used
// [R20] Rx deactivate code default 001001
// [R21] Reserved bits read reset value, ignore writes
// [R22] Writes act in the next cycle
module lmd_maint_ctrl (
	input  wire logic                ref_clk,         // 125 MHz clock
	input  wire logic                resetn,          // Async reset, active low
	input  wire logic                clkEn,           // Freezes all state but the reset synchroniser when low
	input  wire logic                psel,            // APB select
	input  wire logic                penable,         // APB access phase
	input  wire logic                pwrite,          // APB write
	input  wire logic [11:0]         paddr,           // APB byte address
	input  wire logic [31:0]         pwdata,          // APB write data
	output logic                     pready,          // APB ready
	output logic [31:0]              prdata,          // APB read data
	output logic                     pslverr,         // APB unmapped address
	input  wire logic                e1Mode,          // High for E1, low for T1/J1
	input  wire logic                txClkTick,       // Transmit clock bit strobe
	input  wire logic                mstClkTick,      // Master clock bit strobe
	input  wire logic                txDataIn,        // Normal transmit data
	input  wire logic                losDeclared,     // Loss of signal level
	input  wire logic                rxBitTick,       // Receive bit strobe
	input  wire logic                rxPosIn,         // Receive dual rail positive
	input  wire logic                rxNegIn,         // Receive dual rail negative
	output logic                     txLineData,      // Transmit data to encoder
	output logic                     rxPosOut,        // Receive dual rail positive out
	output logic                     rxNegOut,        // Receive dual rail negative out
	output logic                     rxClkOut,        // Receive clock out
	output logic                     aisActive,       // AIS being forced
	output logic                     rxPatternInvert, // Invert for pattern detector
	output logic                     alarmCriterion,  // LOS/AIS rule set
	output lmd_pkg::lmd_loop_s       loopCtrl,        // Loopback enables
	output lmd_pkg::lmd_rxcode_s     rxCodeCfg,       // Receive inband codes
	output logic [1:0]               markThreshold,   // Slicer threshold select
	output logic [1:0]               monitorGain      // Monitor gain select
);

	// Reset synchroniser
	logic rstMeta_q;   // First stage, read only by second
	logic rstSync_q;   // Released reset, active high when 1
	logic rstn;        // Synchronised active-low reset

	// Release reset through two flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign rstn = rstSync_q;

	// Register storage
	logic [7:0] threshGain_q; // Threshold and gain
	logic [7:0] pattAlarm_q;  // Pattern and alarm
	logic [7:0] loopback_q;   // Loopback control
	logic [7:0] codeLen_q;    // Code lengths
	logic [7:0] txCode_q;     // Transmit inband code
	logic [7:0] rxAct_q;      // Receive activate code
	logic [7:0] rxDeact_q;    // Receive deactivate code

	// Bus decode
	logic [9:0] wordIdx;     // Word index from byte address
	logic       accessPh;    // Access phase completing
	logic       wrStrobe;    // Write takes effect this edge
	logic       selThresh;   // Threshold register hit
	logic       selPatt;     // Pattern register hit
	logic       selLoop;     // Loopback register hit
	logic       selLen;      // Length register hit
	logic       selTxCode;   // Tx code hit
	logic       selRxAct;    // Rx activate code hit
	logic       selRxDeact;  // Rx deactivate code hit
	logic       mapped;      // Any register hit
	logic       alignedOk;   // Word aligned
	logic [7:0] rdMux;       // Selected read data
	logic [7:0] wrByte;      // Low byte of write data

	assign wordIdx    = paddr[11:2];
	assign alignedOk  = (paddr[1:0] == 2'b00);
	assign selThresh  = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_THRESH_GAIN});
	assign selPatt    = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_PATT_ALARM});
	assign selLoop    = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_LOOPBACK});
	assign selLen     = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_CODE_LEN});
	assign selTxCode  = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_TX_CODE});
	assign selRxAct   = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_RX_ACT});
	assign selRxDeact = alignedOk && (wordIdx == {2'b00, lmd_pkg::IDX_RX_DEACT});
	assign mapped     = selThresh | selPatt | selLoop | selLen
	                  | selTxCode | selRxAct | selRxDeact;
	// Ready follows the clock enable so a frozen block never completes a transfer
	assign pready     = clkEn;
	assign accessPh   = psel && penable && clkEn;
	assign wrStrobe   = accessPh && pwrite && mapped;
	assign wrByte     = pwdata[7:0];
	// Error only in the access phase of an unmapped transfer
	assign pslverr    = psel && penable && !mapped;

	// Read multiplexer; bits above the byte read as zero
	assign rdMux = selThresh  ? threshGain_q :
	               selPatt    ? pattAlarm_q  :
	               selLoop    ? loopback_q   :
	               selLen     ? codeLen_q    :
	               selTxCode  ? txCode_q     :
	               selRxAct   ? rxAct_q      :
	               selRxDeact ? rxDeact_q    : 8'h00;

	// Read data captured in the setup phase, steady through the access phase
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (clkEn && psel && !penable) begin
			prdata <= {24'h00_0000, rdMux};
		end
	end

	// Merge write data with reserved bits held at reset value
	function automatic logic [7:0] keepRsvd(input logic [7:0] wr,
	                                        input logic [7:0] msk,
	                                        input logic [7:0] rst);
		keepRsvd = (wr & msk) | (rst & ~msk);
	endfunction

	// Configuration register writes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			threshGain_q <= lmd_pkg::RST_THRESH_GAIN; // [R17] [R18]
			pattAlarm_q  <= lmd_pkg::RST_PATT_ALARM;
			loopback_q   <= lmd_pkg::RST_LOOPBACK;
			codeLen_q    <= lmd_pkg::RST_CODE_LEN;    // [R14] [R15] [R16]
		end else if (wrStrobe) begin
			if (selThresh) begin
				threshGain_q <= keepRsvd(wrByte, lmd_pkg::WM_THRESH_GAIN,
				                         lmd_pkg::RST_THRESH_GAIN); // [R21]
			end
			if (selPatt) begin
				pattAlarm_q <= keepRsvd(wrByte, lmd_pkg::WM_PATT_ALARM,
				                        lmd_pkg::RST_PATT_ALARM); // [R21]
			end
			if (selLoop) begin
				loopback_q <= keepRsvd(wrByte, lmd_pkg::WM_LOOPBACK,
				                       lmd_pkg::RST_LOOPBACK); // [R21]
			end
			if (selLen) begin
				codeLen_q <= keepRsvd(wrByte, lmd_pkg::WM_CODE_LEN,
				                      lmd_pkg::RST_CODE_LEN); // [R21]
			end
		end
	end

	// Code register writes; full bytes, no reserved bits
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			txCode_q  <= lmd_pkg::RST_TX_CODE;  // [R19]
			rxAct_q   <= lmd_pkg::RST_RX_ACT;
			rxDeact_q <= lmd_pkg::RST_RX_DEACT; // [R20]
		end else if (wrStrobe) begin
			if (selTxCode) begin
				txCode_q <= wrByte; // [R19]
			end
			if (selRxAct) begin
				rxAct_q <= wrByte;
			end
			if (selRxDeact) begin
				rxDeact_q <= wrByte; // [R20]
			end
		end
	end

	// Field views
	lmd_pkg::lmd_pattern_e pattSel;   // Transmit pattern select
	logic                  pattClk;   // Pattern clock select
	logic                  randInv;   // Random pattern invert
	logic                  aisEn;     // AIS during LOS enable
	logic                  autoOnes;  // Auto all ones enable
	logic [1:0]            txLenSel;  // Tx code length select

	assign pattSel  = lmd_pkg::lmd_pattern_e'(pattAlarm_q[lmd_pkg::PATT_LSB +: 2]);
	assign pattClk  = pattAlarm_q[lmd_pkg::PCLK_BIT];
	assign randInv  = pattAlarm_q[lmd_pkg::PINV_BIT];
	assign aisEn    = pattAlarm_q[lmd_pkg::AIS_DURING_LOS_ENABLE_BIT];
	assign autoOnes = pattAlarm_q[lmd_pkg::AUTO_ALL_ONES_ENABLE_BIT];
	assign txLenSel = codeLen_q[lmd_pkg::TXL_LSB +: 2];

	// Settings go straight out of the registers, so they act the cycle after a write
	assign alarmCriterion     = pattAlarm_q[lmd_pkg::LAC_BIT];       // [R7] [R22]
	assign rxPatternInvert    = randInv;                             // [R6]
	assign loopCtrl.autoRemote = loopback_q[lmd_pkg::AUTO_REMOTE_LOOP_ENABLE_BIT];      // [R10]
	assign loopCtrl.remote     = loopback_q[lmd_pkg::RLP_BIT];       // [R11]
	assign loopCtrl.analog     = loopback_q[lmd_pkg::ALP_BIT];       // [R12]
	assign loopCtrl.digital    = loopback_q[lmd_pkg::DLP_BIT];       // [R13]
	assign markThreshold      = threshGain_q[lmd_pkg::SLICE_LSB +: 2]; // [R17]
	assign monitorGain        = threshGain_q[lmd_pkg::MG_LSB +: 2];    // [R18]
	assign rxCodeCfg.actLength   = codeLen_q[lmd_pkg::RAL_LSB +: 2];  // [R15]
	assign rxCodeCfg.deactLength = codeLen_q[lmd_pkg::RDL_LSB +: 2];  // [R16]
	assign rxCodeCfg.actCode     = rxAct_q;
	assign rxCodeCfg.deactCode   = rxDeact_q;                        // [R20]

	// Pattern timing
	logic internalPat;  // An internal pattern drives the line
	logic autoOnesNow;  // Auto all ones active
	logic patTick;      // Bit strobe for the transmit output

	// Auto all ones only while select is 00 and LOS persists
	assign autoOnesNow = autoOnes && losDeclared && (pattSel == lmd_pkg::PAT_NORMAL); // [R9]
	// Normal data with clock select 0 and no auto all ones is the only case not internally generated
	assign internalPat = !((pattSel == lmd_pkg::PAT_NORMAL) && !pattClk) || autoOnesNow;
	// Internal patterns use the selected reference, normal data the transmit clock
	assign patTick = internalPat ? (pattClk ? mstClkTick : txClkTick) : txClkTick; // [R5]

	// Random sequence generator
	logic [19:0] lfsr_q;    // Shared shift register
	logic        lfsrFb;    // Feedback bit
	logic        lfsrOut;   // Raw random bit
	logic        randBit;   // Random bit after inversion

	// Taps depend on the line standard
	assign lfsrFb  = e1Mode ? (lfsr_q[lmd_pkg::E1_TAP_A] ^ lfsr_q[lmd_pkg::E1_TAP_B])
	                        : (lfsr_q[lmd_pkg::T1_TAP_A] ^ lfsr_q[lmd_pkg::T1_TAP_B]); // [R3]
	assign lfsrOut = e1Mode ? lfsr_q[lmd_pkg::E1_TAP_A] : lfsr_q[lmd_pkg::T1_TAP_A];
	assign randBit = lfsrOut ^ randInv; // [R6]

	// Step once per pattern bit; a zero state would lock up, so reseed it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lfsr_q <= lmd_pkg::LFSR_SEED;
		end else if (clkEn && patTick) begin
			if (lfsr_q == 20'h0_0000) begin
				lfsr_q <= lmd_pkg::LFSR_SEED;
			end else begin
				lfsr_q <= {lfsr_q[18:0], lfsrFb}; // [R3]
			end
		end
	end

	// Inband code sequencer
	logic [2:0] codePtr_q;  // Current bit position in the code
	logic [2:0] codeTop;    // Highest bit used
	logic       codeBit;    // Bit being sent

	// Length select 0..3 means 5..8 bits from bit 0 upward
	assign codeTop = lmd_pkg::CODE_BASE + {1'b0, txLenSel}; // [R14] [R19]
	assign codeBit = txCode_q[codePtr_q];                  // [R4]

	// Sends the highest used bit first, then counts down to bit 0 and repeats
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			codePtr_q <= 3'h4;
		end else if (clkEn && patTick) begin
			if (pattSel != lmd_pkg::PAT_INBAND || codePtr_q == 3'h0 || codePtr_q > codeTop) begin
				codePtr_q <= codeTop; // [R4]
			end else begin
				codePtr_q <= codePtr_q - 3'h1;
			end
		end
	end

	// Transmit source selection
	logic txNext;  // Next transmit bit

	always_comb begin
		txNext = txDataIn;
		unique case (pattSel)
			lmd_pkg::PAT_NORMAL: begin
				// Auto all ones overrides; otherwise data or zeros
				txNext = autoOnesNow ? 1'b1 : (pattClk ? 1'b0 : txDataIn); // [R1] [R9]
			end
			lmd_pkg::PAT_ONES: begin
				txNext = 1'b1; // [R2]
			end
			lmd_pkg::PAT_RANDOM: begin
				txNext = randBit; // [R3] [R6]
			end
			lmd_pkg::PAT_INBAND: begin
				txNext = codeBit; // [R4]
			end
		endcase
	end

	// Transmit output flop, updated on the selected bit strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			txLineData <= 1'b0;
		end else if (clkEn && patTick) begin
			txLineData <= txNext;
		end
	end

	// Receive side AIS forcing
	logic aisNow;     // AIS is to be forced
	logic aisPhase_q; // Alternates marks between rails

	// AIS only while LOS is declared and the enable is set
	assign aisNow = aisEn && losDeclared; // [R8]

	// Receive outputs: dual rail all-ones alternates marks across the two rails
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rxPosOut   <= 1'b0;
			rxNegOut   <= 1'b0;
			aisPhase_q <= 1'b0;
			aisActive  <= 1'b0;
		end else if (clkEn) begin
			aisActive <= aisNow;
			if (aisNow) begin
				// Receive clock may be lost, so AIS is timed by the master clock
				if (mstClkTick) begin
					rxPosOut   <= !aisPhase_q; // [R8]
					rxNegOut   <= aisPhase_q;
					aisPhase_q <= !aisPhase_q;
				end
			end else if (rxBitTick) begin
				rxPosOut <= rxPosIn;
				rxNegOut <= rxNegIn;
			end
		end
	end

	// Receive clock follows the active strobe; one flop keeps it glitch free
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rxClkOut <= 1'b0;
		end else if (clkEn) begin
			rxClkOut <= aisNow ? mstClkTick : rxBitTick; // [R8]
		end
	end

endmodule // lmd_maint_ctrl

//--- verif/lmd_maint_ctrl_props.sv
// Concurrent checks on the maintenance control block ports
`timescale 1ns/1ps
module lmd_maint_ctrl_props (
	input wire logic                 ref_clk,         // Clock
	input wire logic                 resetn,          // Async reset, active low
	input wire logic                 clkEn,           // Clock enable
	input wire logic                 psel,            // APB select
	input wire logic                 penable,         // APB access phase
	input wire logic                 pwrite,          // APB write
	input wire logic [11:0]          paddr,           // APB byte address
	input wire logic [31:0]          pwdata,          // APB write data
	input wire logic                 pready,          // APB ready
	input wire logic                 pslverr,         // APB error
	input wire logic                 txClkTick,       // Transmit strobe
	input wire logic                 mstClkTick,      // Master strobe
	input wire logic                 losDeclared,     // Loss of signal
	input wire logic                 rxBitTick,       // Receive strobe
	input wire logic                 rxPosIn,         // Receive rail in
	input wire logic                 txLineData,      // Transmit bit out
	input wire logic                 rxPosOut,        // Receive rail out
	input wire logic                 aisActive,       // AIS forced
	input wire logic                 rxPatternInvert, // Detector invert
	input wire logic                 alarmCriterion,  // Alarm rule set
	input wire lmd_pkg::lmd_loop_s   loopCtrl,        // Loopback enables
	input wire lmd_pkg::lmd_rxcode_s rxCodeCfg,       // Receive codes
	input wire logic [1:0]           markThreshold,   // Slicer threshold
	input wire logic [1:0]           monitorGain      // Monitor gain
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// Completed write, and whether the address hits a register word
	wire wrDone = psel && penable && pwrite && pready;
	wire mapped = paddr[1:0] == 2'h0 && paddr[11:2] >= 10'h00c && paddr[11:2] <= 10'h012;

	thresh_write_a: assert property (wrDone && paddr == 12'h030 |=>
		markThreshold == $past(pwdata[5:4]) && monitorGain == $past(pwdata[1:0]))
		else $error("threshold or gain not taken from write");
	patt_write_a: assert property (wrDone && paddr == 12'h034 |=>
		rxPatternInvert == $past(pwdata[3]) && alarmCriterion == $past(pwdata[2]))
		else $error("invert or criterion not taken from write");
	loop_write_a: assert property (wrDone && paddr == 12'h038 |=>
		loopCtrl == $past(pwdata[3:0]))
		else $error("loopback enables not taken from write");
	len_write_a: assert property (wrDone && paddr == 12'h03c |=>
		rxCodeCfg.actLength == $past(pwdata[3:2]) && rxCodeCfg.deactLength == $past(pwdata[1:0]))
		else $error("receive code lengths not taken from write");
	addr_decode_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("error response does not match address map");
	// A line without loss of signal can never be replaced by AIS
	no_ais_a: assert property (clkEn && !losDeclared |=> !aisActive)
		else $error("AIS forced without loss of signal");
	ais_cause_a: assert property ($rose(aisActive) |-> $past(losDeclared))
		else $error("AIS started without prior loss of signal");
	// Pattern bits only move on a bit strobe
	tx_hold_a: assert property (!txClkTick && !mstClkTick |=> $stable(txLineData))
		else $error("transmit bit changed without a strobe");
	rx_pass_a: assert property (clkEn && rxBitTick && !losDeclared && !aisActive |=>
		rxPosOut == $past(rxPosIn))
		else $error("receive data not passed while AIS is off");
endmodule // lmd_maint_ctrl_props

//--- verif/lmd_maint_ctrl_tb_top.sv
// Self-checking bench for the line maintenance control block
`timescale 1ns/1ps
module lmd_maint_ctrl_tb_top;
	logic                 ref_clk, resetn, clkEn, psel, penable, pwrite, pready, pslverr; // APB
	logic [11:0]          paddr;           // APB byte address
	logic [31:0]          pwdata, prdata, rdVal; // APB data and last read
	logic                 e1Mode, txClkTick, mstClkTick, txDataIn, losDeclared; // Tx side
	logic                 rxBitTick, rxPosIn, rxNegIn, rxPosOut, rxNegOut, rxClkOut; // Rx side
	logic                 txLineData, aisActive, rxPatternInvert, alarmCriterion; // Outputs
	logic                 lastErr, bitV;   // Last error flag and last line bit
	logic [2:0]           rxV;             // Receive clock and rails after a strobe
	logic [1:0]           markThreshold, monitorGain; // Receiver selects
	lmd_pkg::lmd_loop_s   loopCtrl;        // Loopback enables
	lmd_pkg::lmd_rxcode_s rxCodeCfg;       // Receive codes
	logic [39:0]          seq;             // Captured line bits
	int                   num_errors = 0;  // Mismatch count
	int                   samples_checked = 0; // Comparison count

	lmd_maint_ctrl dut_u (.*);

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdVal = prdata;
		lastErr = pslverr;
		if (n >= 20) num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(rdVal, {24'h00_0000, e});
	endtask

	// One bit strobe; the line bit is taken in the following cycle
	task automatic tick(input logic mst, input logic d);
		txDataIn <= d;
		rxPosIn <= d;
		rxNegIn <= ~d;
		rxBitTick <= 1'b1;
		if (mst) mstClkTick <= 1'b1;
		else txClkTick <= 1'b1;
		@(posedge ref_clk);
		{mstClkTick, txClkTick, rxBitTick} <= 3'h0;
		#1 bitV = txLineData;
		rxV = {rxClkOut, rxPosOut, rxNegOut};
		@(posedge ref_clk);
	endtask

	task automatic grab(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			tick(1'b0, i[0]);
			seq[i] = bitV;
		end
	endtask

	// Bits must be a rotation of the code, sent from its top used bit down
	function automatic logic codeOk(input logic [39:0] s, input logic [7:0] c, input int len);
		logic ok;
		for (int r = 0; r < len; r++) begin
			ok = 1'b1;
			for (int i = 0; i < 2 * len; i++)
				if (s[i] !== c[len - 1 - ((i + r) % len)]) ok = 1'b0;
			if (ok) return 1'b1;
		end
		return 1'b0;
	endfunction

	// Generator recurrence; either tap order is accepted since shift direction is free
	function automatic logic recurOk(input logic [39:0] s, input int len, input int tap,
			input logic inv);
		logic a, b;
		a = 1'b1;
		b = 1'b1;
		for (int n = len; n < 40; n++) begin
			if (s[n] !== (s[n - len] ^ s[n - tap] ^ inv)) a = 1'b0;
			if (s[n] !== (s[n - len] ^ s[n - len + tap] ^ inv)) b = 1'b0;
		end
		return a | b;
	endfunction

	// Watchdog: the sequence needs about 1200 cycles
	initial begin
		repeat (8000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{txClkTick, mstClkTick, txDataIn, losDeclared, rxBitTick, rxPosIn, rxNegIn} = '0;
		clkEn = 1'b1;
		e1Mode = 1'b1;
		resetn = 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdChk(12'h030, 8'h18);
		rdChk(12'h034, 8'h00);
		rdChk(12'h038, 8'h00);
		rdChk(12'h03c, 8'h01);
		rdChk(12'h040, 8'h01);
		rdChk(12'h044, 8'h01);
		rdChk(12'h048, 8'h09);
		check(rxCodeCfg, {2'h0, 8'h01, 2'h1, 8'h09});
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 12'h030, {2'h0, k[1:0], 2'h0, k[1:0]});
			check({markThreshold, monitorGain}, {k[1:0], k[1:0]});
		end
		apb(1'b1, 12'h030, 8'hff);
		rdChk(12'h030, 8'h3b);
		apb(1'b1, 12'h03c, 8'hff);
		rdChk(12'h03c, 8'h3f);
		apb(1'b1, 12'h038, 8'hff);
		rdChk(12'h038, 8'h0f);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h038, 8'h01 << i);
			check(loopCtrl, 4'h1 << i);
		end
		apb(1'b1, 12'h044, 8'ha5);
		check(rxCodeCfg.actCode, 8'ha5);
		apb(1'b1, 12'h048, 8'h5a);
		check(rxCodeCfg.deactCode, 8'h5a);
		apb(1'b1, 12'h04c, 8'h55);
		check(lastErr, 1'b1);
		rdChk(12'h031, 8'h00);
		apb(1'b1, 12'h034, 8'h0c);
		check({rxPatternInvert, alarmCriterion}, 2'h3);
		apb(1'b1, 12'h034, 8'h00);
		tick(1'b0, 1'b0);
		check(bitV, 1'b0);
		tick(1'b0, 1'b1);
		check(bitV, 1'b1);
		// A frozen block keeps its line bit and never answers the bus
		clkEn <= 1'b0;
		tick(1'b0, 1'b0);
		check({pready, bitV}, 2'h1);
		clkEn <= 1'b1;
		apb(1'b1, 12'h034, 8'h10);
		tick(1'b0, 1'b1);
		check(bitV, 1'b1);
		tick(1'b1, 1'b1);
		check(bitV, 1'b0);
		// All ones timed by the master strobe ignores the transmit strobe
		apb(1'b1, 12'h034, 8'h30);
		tick(1'b0, 1'b1);
		check(bitV, 1'b0);
		tick(1'b1, 1'b0);
		check(bitV, 1'b1);
		apb(1'b1, 12'h034, 8'h20);
		tick(1'b0, 1'b0);
		check(bitV, 1'b1);
		apb(1'b1, 12'h034, 8'h01);
		losDeclared <= 1'b1;
		tick(1'b0, 1'b0);
		check(bitV, 1'b1);
		check(aisActive, 1'b0);
		losDeclared <= 1'b0;
		tick(1'b0, 1'b0);
		check(bitV, 1'b0);
		apb(1'b1, 12'h034, 8'h02);
		losDeclared <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check(aisActive, 1'b1);
		// Marks alternate across the rails on each master strobe
		tick(1'b1, 1'b0);
		check(rxV, 3'h6);
		tick(1'b1, 1'b0);
		check(rxV, 3'h5);
		losDeclared <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(aisActive, 1'b0);
		tick(1'b0, 1'b1);
		check(rxV, 3'h6);
		apb(1'b1, 12'h03c, 8'h00);
		apb(1'b1, 12'h034, 8'h60);
		grab(12);
		grab(40);
		check(codeOk(seq, 8'h01, 5), 1'b1);
		apb(1'b1, 12'h040, 8'hb4);
		for (int l = 0; l < 4; l++) begin
			apb(1'b1, 12'h03c, {2'h0, l[1:0], 4'h0});
			grab(12);
			grab(40);
			check(codeOk(seq, 8'hb4, l + 5), 1'b1);
		end
		for (int m = 0; m < 4; m++) begin
			e1Mode <= m[0];
			apb(1'b1, 12'h034, {1'b0, 2'h2, 1'b0, m[1], 3'h0});
			grab(25);
			grab(40);
			check(recurOk(seq, m[0] ? 15 : 20, m[0] ? 14 : 17, m[1]), 1'b1);
			check(|seq && !(&seq), 1'b1);
		end
		test_done();
	end
endmodule // lmd_maint_ctrl_tb_top

bind lmd_maint_ctrl lmd_maint_ctrl_props props_u (.*);
